// file: hist_mem.v
`include "xarm_map.vh"
module hist_mem #(
  parameter W = 16,
  parameter N = 8,
  parameter AW = 3
) (
  // clock
  input  wire          clk,
  // write side
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  // read side
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);
  reg [W-1:0] mem [0:N-1];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // hist_mem

// file: target_sys.sv
module target_sys (
  // clock
  input wire logic        clk,
  // requested levels
  input wire logic [15:0] state_word,
  input wire logic [7:0]  timing_bits,
  input wire logic [7:0]  mclk_bits,
  // probe pins
  output logic     [64:0] probe,
  output logic     [7:0]  mclk_field
);
  timeunit 1ns;
  timeprecision 1ns;
  logic noise = 1'b0;
  // unused state channels never sit still, so a sloppy compare cannot hide
  always @(posedge clk) noise <= ~noise;
  assign probe = {{41{noise}}, state_word, timing_bits};
  assign mclk_field = mclk_bits;
endmodule // target_sys

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] ctl; logic [1:0] mode; logic [7:0] mclk;} row_t;
  row_t        rows [4] = '{'{32'h000, 2'h0, 8'hA5}, '{32'h008, 2'h1, 8'hA5},
                            '{32'h030, 2'h2, 8'h00}, '{32'h020, 2'h0, 8'h00}};
  logic        clk = 1'b0;
  logic        rst_n, wr, rd, state_store, timing_store, irq;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [15:0] sw, state_line;
  logic [7:0]  tw, mk, mclk_field, mclk_used, timing_data;
  logic [1:0]  trace_mode;
  logic [64:0] probe;
  logic [56:0] state_data;
  int          failures = 0;
  int          samples_checked = 0;
  always #25 clk = ~clk;
  target_sys target_sys_inst (.clk(clk), .state_word(sw), .timing_bits(tw), .mclk_bits(mk),
    .probe(probe), .mclk_field(mclk_field));
  xarm_seq #(.PROBES(65), .DLY_W(16)) xarm_seq_inst (.CLK(clk), .RST_N(rst_n), .PROBE(probe),
    .MCLK_FIELD(mclk_field), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .STATE_STORE(state_store), .TIMING_STORE(timing_store), .STATE_LINE(state_line), .STATE_DATA(state_data),
    .TIMING_DATA(timing_data), .MCLK_USED(mclk_used), .TRACE_MODE(trace_mode), .IRQ(irq));
  // ==================================================
  // helpers
  task automatic complete_run;
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_store(input logic tim);
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      #1;
      if ((tim ? timing_store : state_store) === 1'b1) return;
    end
    failures++;
    complete_run;
  endtask
  // ==================================================
  // main sequence
  initial begin
    {rst_n, wr, rd, addr, wdata, sw, tw} = '0;
    mk = 8'hA5;
    repeat (10) @(posedge clk);
    #1 chk("reset outputs", 32'h0, {state_line, mclk_used, trace_mode, state_store, timing_store, irq});
    @(posedge clk) rst_n <= 1'b1;
    rd_reg(4'hF, got);
    chk("unmapped read", 32'h0, got);
    foreach (rows[i]) begin
      wr_reg(4'h0, rows[i].ctl);
      repeat (4) @(posedge clk);
      #1 chk("trace mode", rows[i].mode, trace_mode);
      chk("clock field", rows[i].mclk, mclk_used);
    end
    // state master, timing slave on a rising edge of timing_channel_two
    wr_reg(4'h1, 32'h1234);
    wr_reg(4'h7, 32'h7);
    wr_reg(4'h0, 32'h221);
    repeat (4) @(posedge clk);
    rd_reg(4'h5, got);
    chk("status searching", 32'h003, got);
    @(posedge clk) sw <= 16'h1234;
    wait_store(1'b0);
    chk("slave idle at master store", 32'h0, timing_store);
    rd_reg(4'h5, got);
    chk("status armed", 32'h042, got);
    @(posedge clk) tw <= 8'h04;
    wait_store(1'b1);
    repeat (40) @(posedge clk);
    rd_reg(4'h5, got);
    chk("status both done", 32'h03C, got);
    chk("irq raised", 32'h1, irq);
    rd_reg(4'h6, got);
    chk("irq events", 32'h3, got);
    @(posedge clk);
    #1 chk("irq cleared", 32'h0, irq);
    // stop with the timing engine still waiting, events masked
    @(posedge clk);
    sw <= 16'h0;
    tw <= 8'h00;
    wr_reg(4'h7, 32'h0);
    wr_reg(4'h0, 32'h221);
    @(posedge clk) sw <= 16'h1234;
    wait_store(1'b0);
    repeat (40) @(posedge clk);
    rd_reg(4'h5, got);
    chk("status timing pending", 32'h046, got);
    chk("irq masked", 32'h0, irq);
    wr_reg(4'h0, 32'h222);
    repeat (4) @(posedge clk);
    rd_reg(4'h5, got);
    chk("status aborted", 32'h294, got);
    rd_reg(4'h6, got);
    chk("irq abort events", 32'h5, got);
    wr_reg(4'h8, 32'h0);
    rd_reg(4'h8, got);
    chk("history kept", 32'h1234, got);
    // delayed master, don't-care slave
    @(posedge clk);
    sw <= 16'h0;
    wr_reg(4'h4, 32'h5);
    wr_reg(4'h0, 32'h2A1);
    @(posedge clk) sw <= 16'h1234;
    wait_store(1'b1);
    chk("master waits its delay", 32'h0, state_store);
    wait_store(1'b0);
    repeat (40) @(posedge clk);
    // timing master with pattern XXXX1X1X
    wr_reg(4'h4, 32'h0);
    wr_reg(4'h2, 32'h0A);
    wr_reg(4'h3, 32'h0A);
    wr_reg(4'h0, 32'h225);
    @(posedge clk) tw <= 8'h04;
    repeat (8) @(posedge clk);
    tw <= 8'h0A;
    repeat (8) @(posedge clk);
    #1 chk("no store before pattern edge", 32'h0, {state_store, timing_store});
    chk("timing channels", 32'h0A, timing_data);
    chk("state channels", 32'h1234, state_data[15:0]);
    chk("narrow state top", 32'h0, state_data[56:27]);
    @(posedge clk) tw <= 8'h0E;
    wait_store(1'b1);
    chk("state held off", 32'h0, state_store);
    wait_store(1'b0);
    repeat (40) @(posedge clk);
    rd_reg(4'h5, got);
    chk("status timing master done", 32'h03C, got);
    complete_run;
  end
endmodule // tb_top

// file: xarm_map.vh
`ifndef XARM_MAP_VH
`define XARM_MAP_VH
// ==================================================
// register addresses
`define A_CTRL      4'h0
`define A_STRIG     4'h1
`define A_TPAT      4'h2
`define A_TCARE     4'h3
`define A_DELAY     4'h4
`define A_STATUS    4'h5
`define A_IRQ       4'h6
`define A_MASK      4'h7
`define A_HIST      4'h8
// ==================================================
// control fields
`define C_RUN       0
`define C_STOP      1
`define C_MSTIME    2
`define C_MODE_LO   3
`define C_MODE_HI   4
`define C_INTER     5
`define C_WIDE      6
`define C_SDC       7
`define C_ESEL_LO   8
`define C_ESEL_HI   10
// ==================================================
// status fields
`define S_SWAIT     0
`define S_TWAIT     1
`define S_SDONE     2
`define S_TDONE     3
`define S_SVALID    4
`define S_TVALID    5
`define S_ARM       6
`define S_ABORT     7
`define S_SBAD      8
`define S_TBAD      9
// ==================================================
// irq bits
`define I_TRIG      0
`define I_DONE      1
`define I_ABORT     2
`define IRQ_W       3
// ==================================================
// trace modes
`define M_SINGLE    2'h0
`define M_CONT      2'h1
`define M_COMPARE   2'h2
// ==================================================
// sizes
`define TIM_CH      8
`define HIST_N      8
`define POD_W       8
`define STATE_NARROW 27
`define STATE_WIDE  57
`define TRIG_LINE   16'h0000
`define POST_LEN    16'h0010
`define ZERO32      32'h00000000
`endif

// file: xarm_seq.v
// Notes on behaviour
// - at run start only the master engine searches, the slave search is held off.
// - the master trigger raises an arm level that alone lets the slave search.
// - an all-don't-care slave with zero delay stores one cycle after arming; a delayed master stores after its count.
// - results are shown valid once both engines have completed, or for a finished engine after a stop aborts.
// - a stop with one engine incomplete shows the finished one and flags the other invalid.
// - a master select chooses state or timing; timing master must trigger before state searches.
// - interactive mode gives 8 channels to timing and 27 or 57 to state.
// - interactive state input drops the low 8-bit pod and the multiplexed clock field loses 8 bits.
// - an unmet trigger shows waiting status; stop aborts and keeps the last eight samples.
// - timing trigger is a per-bit pattern match and a rising edge on the chosen channel.
// - the master starts storing in the same cycle it raises the arm level.
// - the state sample index is zero at the trigger, with later samples counted up from it.
// - both engines share one trace mode setting.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`include "xarm_map.vh"
module xarm_seq #(
  parameter PROBES = 65,
  parameter DLY_W = 16
) (
  // clock and reset
  input  wire              CLK,
  input  wire              RST_N,
  // probe pins
  input  wire [PROBES-1:0] PROBE,
  input  wire [7:0]        MCLK_FIELD,
  // register port
  input  wire [3:0]        ADDR,
  input  wire [31:0]       WDATA,
  input  wire              WR,
  input  wire              RD,
  output reg  [31:0]       RDATA,
  // capture outputs
  output reg               STATE_STORE,
  output reg               TIMING_STORE,
  output reg  [15:0]       STATE_LINE,
  output reg  [56:0]       STATE_DATA,
  output reg  [7:0]        TIMING_DATA,
  output reg  [7:0]        MCLK_USED,
  output reg  [1:0]        TRACE_MODE,
  // interrupt
  output wire              IRQ
);
  // ==================================================
  // pin synchronisers
  reg [PROBES-1:0] p_meta;
  reg [PROBES-1:0] p_sync;
  reg [7:0]        c_meta;
  reg [7:0]        c_sync;
  always @(posedge CLK) begin
    p_meta <= PROBE;
    p_sync <= p_meta;
    c_meta <= MCLK_FIELD;
    c_sync <= c_meta;
  end
  // ==================================================
  // registers
  reg [10:0]      ctrl;
  reg [15:0]      strig;
  reg [7:0]       tpat;
  reg [7:0]       tcare;
  reg [DLY_W-1:0] delay;
  reg [`IRQ_W-1:0] irq_st;
  reg [`IRQ_W-1:0] irq_mask;
  reg [2:0]       hist_sel;
  wire ms_timing = ctrl[`C_MSTIME];
  wire inter     = ctrl[`C_INTER];
  wire [2:0] esel = ctrl[`C_ESEL_HI:`C_ESEL_LO];
  // ==================================================
  // channel split
  reg [56:0] s_in;
  reg [7:0]  t_in;
  integer i;
  always @* begin
    s_in = 57'h0;
    t_in = 8'h0;
    if (inter) begin
      t_in = p_sync[`TIM_CH-1:0];
      for (i = 0; i < `STATE_WIDE; i = i + 1) begin
        // low pod goes to timing; wide variant keeps 57 state bits
        if (ctrl[`C_WIDE] || i < `STATE_NARROW) begin
          s_in[i] = p_sync[i+`POD_W];
        end
      end
    end else begin
      for (i = 0; i < `STATE_WIDE; i = i + 1) begin
        s_in[i] = p_sync[i];
      end
    end
  end
  // ==================================================
  // trigger detection
  reg  [7:0] t_prev;
  wire pat_ok   = ((t_in ^ tpat) & tcare) == 8'h00;
  wire edge_ok  = t_in[esel] & ~t_prev[esel];
  wire t_hit    = pat_ok & edge_ok;
  wire s_hit    = s_in[15:0] == strig;
  // ==================================================
  // sequencer
  reg running;
  reg armed;
  reg m_found;
  reg m_store;
  reg s_done;
  reg t_done;
  reg s_trg;
  reg t_trg;
  reg aborted;
  reg s_bad;
  reg t_bad;
  reg [DLY_W-1:0] dcnt;
  reg [15:0] s_post;
  reg [15:0] t_post;
  wire m_hit   = ms_timing ? t_hit : s_hit;
  wire m_srch  = running & ~m_found;
  wire m_arm   = m_srch & m_hit;
  // a don't-care slave trigger is met as soon as it is armed
  wire sl_hit  = ctrl[`C_SDC] ? 1'b1 : (ms_timing ? s_hit : t_hit);
  wire sl_srch = running & armed;
  wire ctl_wr  = WR && ADDR == `A_CTRL;
  wire start   = ctl_wr && WDATA[`C_RUN];
  wire stop    = ctl_wr && WDATA[`C_STOP];
  wire dly_zero = (delay == {DLY_W{1'b0}});
  wire dly_end = m_found & ~m_store & (dcnt == delay);
  wire m_tp    = dly_end | (m_arm & dly_zero);
  wire both    = s_done & t_done;
  wire s_trig_now = ms_timing ? (sl_srch & ~s_trg & sl_hit) : m_tp;
  wire t_trig_now = ms_timing ? m_tp : (sl_srch & ~t_trg & sl_hit);
  always @(posedge CLK) begin
    if (!RST_N) begin
      running <= 1'b0;
      armed   <= 1'b0;
      m_found <= 1'b0;
      m_store <= 1'b0;
      s_done  <= 1'b0;
      t_done  <= 1'b0;
      s_trg   <= 1'b0;
      t_trg   <= 1'b0;
      aborted <= 1'b0;
      s_bad   <= 1'b0;
      t_bad   <= 1'b0;
      dcnt    <= {DLY_W{1'b0}};
      s_post  <= 16'h0000;
      t_post  <= 16'h0000;
      t_prev  <= 8'h00;
    end else begin
      t_prev <= t_in;
      if (start) begin
        running <= 1'b1;
        armed   <= 1'b0;
        m_found <= 1'b0;
        m_store <= 1'b0;
        s_done  <= 1'b0;
        t_done  <= 1'b0;
        s_trg   <= 1'b0;
        t_trg   <= 1'b0;
        aborted <= 1'b0;
        s_bad   <= 1'b0;
        t_bad   <= 1'b0;
        dcnt    <= {DLY_W{1'b0}};
      end else if (running) begin
        if (stop) begin
          running <= 1'b0;
          armed   <= 1'b0;
          aborted <= ~both;
          s_bad   <= ~s_done;
          t_bad   <= ~t_done;
        end else begin
          if (m_arm) begin
            m_found <= 1'b1;
            armed   <= 1'b1;
          end
          if (m_found & ~m_store) begin
            dcnt <= dcnt + 1'b1;
          end
          if (m_tp) begin
            m_store <= 1'b1;
          end
          if (s_trig_now) begin
            s_trg  <= 1'b1;
            s_post <= 16'h0000;
          end else if (s_trg & ~s_done) begin
            s_post <= s_post + 16'h0001;
            if (s_post == `POST_LEN) begin
              s_done <= 1'b1;
            end
          end
          if (t_trig_now) begin
            t_trg  <= 1'b1;
            t_post <= 16'h0000;
          end else if (t_trg & ~t_done) begin
            t_post <= t_post + 16'h0001;
            if (t_post == `POST_LEN) begin
              t_done <= 1'b1;
            end
          end
          if (both) begin
            // continuous mode restarts and drops arm; other modes drop arm and end the run
            if (TRACE_MODE == `M_CONT) begin
              armed   <= 1'b0;
              m_found <= 1'b0;
              m_store <= 1'b0;
              s_done  <= 1'b0;
              t_done  <= 1'b0;
              s_trg   <= 1'b0;
              t_trg   <= 1'b0;
              dcnt    <= {DLY_W{1'b0}};
            end else begin
              running <= 1'b0;
              armed   <= 1'b0;
            end
          end
        end
      end
    end
  end
  // ==================================================
  // capture outputs
  // master stores in the arm cycle, even if tracepoint is delayed
  wire s_store_now = s_trig_now | (s_trg & ~s_done) | (~ms_timing & m_arm);
  wire t_store_now = t_trig_now | (t_trg & ~t_done) | (ms_timing & m_arm);
  always @(posedge CLK) begin
    if (!RST_N) begin
      STATE_STORE  <= 1'b0;
      TIMING_STORE <= 1'b0;
      STATE_LINE   <= 16'h0000;
      STATE_DATA   <= 57'h0;
      TIMING_DATA  <= 8'h00;
      MCLK_USED    <= 8'h00;
      TRACE_MODE   <= `M_SINGLE;
    end else begin
      TRACE_MODE   <= ctrl[`C_MODE_HI:`C_MODE_LO];
      STATE_STORE  <= running & s_store_now;
      TIMING_STORE <= running & t_store_now;
      STATE_DATA   <= s_in;
      TIMING_DATA  <= t_in;
      MCLK_USED    <= inter ? 8'h00 : c_sync;
      if (s_trig_now) begin
        STATE_LINE <= `TRIG_LINE;
      end else if (running) begin
        STATE_LINE <= STATE_LINE + 16'h0001;
      end
    end
  end
  // ==================================================
  // last-eight history, written while running
  reg  [2:0]  h_wp;
  wire [15:0] h_rd;
  wire [2:0]  h_ra = h_wp + hist_sel;
  always @(posedge CLK) begin
    if (!RST_N) begin
      h_wp <= 3'h0;
    end else if (running) begin
      h_wp <= h_wp + 3'h1;
    end
  end
  hist_mem #(
    .W  (16),
    .N  (`HIST_N),
    .AW (3)
  ) u_hist (
    .clk   (CLK),
    .we    (running),
    .waddr (h_wp),
    .wdata (s_in[15:0]),
    .raddr (h_ra),
    .rdata (h_rd)
  );
  // ==================================================
  // status and interrupts
  wire s_wait  = running & ~s_trg;
  // a slave still held off also waits, its trigger is unmet
  wire t_wait  = running & ~t_trg;
  wire s_valid = both | (aborted & s_done);
  wire t_valid = both | (aborted & t_done);
  wire [`IRQ_W-1:0] ev;
  assign ev[`I_TRIG]  = running & m_srch & m_hit;
  assign ev[`I_DONE]  = running & both;
  assign ev[`I_ABORT] = running & stop;
  assign IRQ = |(irq_st & irq_mask);
  wire [31:0] status = {
    22'h0,
    t_bad,
    s_bad,
    aborted,
    armed,
    t_valid,
    s_valid,
    t_done,
    s_done,
    t_wait,
    s_wait
  };
  always @(posedge CLK) begin
    if (!RST_N) begin
      ctrl     <= 11'h000;
      strig    <= 16'h0000;
      tpat     <= 8'h00;
      tcare    <= 8'h00;
      delay    <= {DLY_W{1'b0}};
      irq_mask <= {`IRQ_W{1'b0}};
      irq_st   <= {`IRQ_W{1'b0}};
      hist_sel <= 3'h0;
      RDATA    <= `ZERO32;
    end else begin
      if (WR) begin
        case (ADDR)
          `A_CTRL:  ctrl     <= {WDATA[10:2], 2'b00};
          `A_STRIG: strig    <= WDATA[15:0];
          `A_TPAT:  tpat     <= WDATA[7:0];
          `A_TCARE: tcare    <= WDATA[7:0];
          `A_DELAY: delay    <= WDATA[DLY_W-1:0];
          `A_MASK:  irq_mask <= WDATA[`IRQ_W-1:0];
          `A_HIST:  hist_sel <= WDATA[2:0];
          default:  ;
        endcase
      end
      // set wins over the read clear
      if (RD && ADDR == `A_IRQ) begin
        irq_st <= ev;
      end else begin
        irq_st <= irq_st | ev;
      end
      RDATA  <= `ZERO32;
      if (RD) begin
        case (ADDR)
          `A_CTRL:   RDATA <= {21'h0, ctrl};
          `A_STRIG:  RDATA <= {16'h0, strig};
          `A_TPAT:   RDATA <= {24'h0, tpat};
          `A_TCARE:  RDATA <= {24'h0, tcare};
          `A_DELAY:  RDATA <= {{(32-DLY_W){1'b0}}, delay};
          `A_STATUS: RDATA <= status;
          `A_IRQ:    RDATA <= {29'h0, irq_st};
          `A_MASK:   RDATA <= {29'h0, irq_mask};
          `A_HIST:   RDATA <= {16'h0, h_rd};
          default:   RDATA <= `ZERO32;
        endcase
      end
    end
  end
endmodule // xarm_seq

// file: xarm_seq_monitor.sv
module xarm_seq_monitor (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // register port
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // capture outputs
  input wire logic        STATE_STORE,
  input wire logic        TIMING_STORE,
  input wire logic [15:0] STATE_LINE,
  input wire logic [7:0]  MCLK_USED,
  input wire logic [1:0]  TRACE_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==================================================
  // shadow of the control word
  logic       inter, mst, sdc, s_seen, t_seen;
  logic [1:0] wr_mode;
  wire        ctl_wr = WR && ADDR == 4'h0;
  logic       dly_on;
  // a delayed state master stores once at arming, then waits for its trace point
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dly_on <= 1'b0;
    end else if (WR && ADDR == 4'h4) begin
      dly_on <= |WDATA[15:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      {inter, mst, sdc, s_seen, t_seen, wr_mode} <= 7'h00;
    end else begin
      if (ctl_wr) begin
        {sdc, inter, wr_mode, mst} <= {WDATA[7], WDATA[5:2]};
      end
      // a run start forgets which engine stored first
      s_seen <= (ctl_wr && WDATA[0]) ? 1'b0 : (s_seen | STATE_STORE);
      t_seen <= (ctl_wr && WDATA[0]) ? 1'b0 : (t_seen | TIMING_STORE);
    end
  end
  // ==================================================
  // properties
  sequence s_ctl_steady; $stable(wr_mode) [*4]; endsequence
  sequence s_tim_burst; TIMING_STORE [*8]; endsequence
  property p_rdata_idle; !$past(RD) |-> RDATA == 32'h00000000; endproperty
  property p_unmapped; RD && ADDR > 4'h8 |=> RDATA == 32'h00000000; endproperty
  property p_line_zero; $rose(STATE_STORE) && (mst || !dly_on || s_seen) |-> STATE_LINE == 16'h0000; endproperty
  property p_master_wait; $rose(STATE_STORE) && !mst && dly_on && !s_seen |=> !STATE_STORE; endproperty
  property p_line_step;
    STATE_STORE && $past(STATE_STORE) |-> STATE_LINE == $past(STATE_LINE) + 16'h0001;
  endproperty
  property p_tim_len; $rose(TIMING_STORE) |-> s_tim_burst ##[1:12] !TIMING_STORE; endproperty
  property p_mode; s_ctl_steady |-> TRACE_MODE == wr_mode; endproperty
  property p_mclk; inter [*4] |-> MCLK_USED == 8'h00; endproperty
  property p_slave_after; $rose(TIMING_STORE) && !mst && !sdc |-> s_seen || STATE_STORE; endproperty
  property p_state_after; $rose(STATE_STORE) && mst |-> t_seen || TIMING_STORE; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_line_zero: assert property (p_line_zero) else $error("trigger sample not on line zero");
  a_line_step: assert property (p_line_step) else $error("sample line not counting");
  a_master_wait: assert property (p_master_wait) else $error("delayed master stored early");
  a_tim_len: assert property (p_tim_len) else $error("timing capture length wrong");
  a_mode: assert property (p_mode) else $error("trace mode not following control");
  a_mclk: assert property (p_mclk) else $error("clock field not narrowed");
  a_slave_after: assert property (p_slave_after) else $error("slave stored before master");
  a_state_after: assert property (p_state_after) else $error("state stored before timing");
endmodule // xarm_seq_monitor

bind xarm_seq xarm_seq_monitor xarm_seq_monitor_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .STATE_STORE(STATE_STORE), .TIMING_STORE(TIMING_STORE),
  .STATE_LINE(STATE_LINE), .MCLK_USED(MCLK_USED), .TRACE_MODE(TRACE_MODE));
